/* hw/lock_ctl_pkg.sv */
// Purpose: Constants shared by the block lock and status host controller.
// Assumes: Asynchronous parallel NOR flash with a 16-bit data bus.
// Notes: Command codes and timings are plain defaults held as parameters.
package lock_ctl_pkg;
    // =========================================================
    // Device command codes.
    localparam logic [7:0] CMD_LOCK_SETUP = 8'h60;
    localparam logic [7:0] CMD_LOCK_SET = 8'h01;
    localparam logic [7:0] CMD_LOCK_CLEAR = 8'hd0;
    localparam logic [7:0] CMD_STATUS_READ = 8'h70;
    localparam logic [7:0] CMD_STATUS_CLEAR = 8'h50;
    localparam logic [7:0] CMD_INFO_READ = 8'h90;
    localparam logic [7:0] CMD_ARRAY_READ = 8'hff;
    localparam logic [15:0] LOCK_INFO_OFFSET = 16'h0002;
    // =========================================================
    // Device status bit positions and reset value.
    localparam int SR_READY = 7;
    localparam int SR_ERASE_PAUSED = 6;
    localparam int SR_ERASE_FAIL = 5;
    localparam int SR_WRITE_FAIL = 4;
    localparam int SR_SUPPLY_FAULT = 3;
    localparam int SR_WRITE_PAUSED = 2;
    localparam int SR_PROTECTED = 1;
    localparam logic [7:0] SR_RESET = 8'h80;
    // =========================================================
    // Controller register offsets (word index on the local port).
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ADDR = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [3:0] REG_RESULT = 4'h3;
    // Control codes written to REG_CTRL bits 2:0.
    localparam logic [2:0] OP_LOCK = 3'h1;
    localparam logic [2:0] OP_UNLOCK_ALL = 3'h2;
    localparam logic [2:0] OP_QUERY = 3'h3;
    localparam logic [2:0] OP_CLEAR = 3'h4;
    localparam logic [2:0] OP_STATUS = 3'h5;
    // =========================================================
    // Bus timing, in nanoseconds and in 5 ns cycles.
    localparam int CLK_NS = 5;
    localparam int T_STROBE_NS = 70;
    localparam int T_RECOVER_NS = 30;
    localparam logic [4:0] STROBE_CYC = 5'((T_STROBE_NS + CLK_NS - 1) / CLK_NS);
    localparam logic [4:0] RECOVER_CYC =
        5'((T_RECOVER_NS + CLK_NS - 1) / CLK_NS);
endpackage

/* hw/lock_ctl.sv */
// Purpose: Host controller that locks, unlocks and queries flash blocks.
// Assumes: Single clock; device pins are outside the domain.
// Notes: Status reads are single reads only, each with its own strobe.
`timescale 1ns/1ps
`default_nettype none

// Contract
// (R1) Lock one block by writing the set-lock pair inside that block.
// (R2) Unlock all blocks with the clear-locks pair at any address.
// (R3) After the setup cycle, reads return device status.
// (R4) Completion shows as ready pin high and status bit 7 set.
// (R5) Never issue lock or unlock while busy or suspended.
// (R6) Lock bits stay unchanged while write supply is at lockout.
// (R7) Check bit 4 after set-lock and bit 5 after clear-locks.
// (R8) Info read at block base plus 02h gives lock state on bit 0.
// (R9) Program or erase with supply grounded fails with error flag.
// (R10) Status reads carry status in low byte and zero in high byte.
// (R11) Status holds 80h after power-up and reset.
// (R12) Use single reads in status mode, never page bursts.
// (R13) Toggle output enable between reads to see fresh status.
// (R14) Status read and status clear work at any supply level.
// (R15) Bit 6 marks erase suspended, bit 2 program suspended.
// (R16) Bits 5 and 4 flag erase and program failure.
// (R17) Bit 1 marks an aborted operation on a locked block.
// (R18) Bit 0 is reserved and reads zero.
// (R19) Bits 7,6,2 follow the sequencer; 5,4,3,1 stay until cleared.
// (R20) Device reset clears status like the clear command.
// (R21) Clear status before starting each new command sequence; the code clears only before lock and unlock pairs.
// (R22) Erase is ignored while earlier error flags stand.
// (R23) Ready pin low while busy, high when ready or suspended.
module lock_ctl (
    input wire logic clock,
    input wire logic resetn,
    input wire logic [3:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    output logic [22:0] flash_addr,
    output logic [15:0] flash_dq_out,
    output logic flash_dq_oe,
    input wire logic [15:0] flash_dq_in,
    output logic chip_enable_n,
    output logic write_enable_n,
    output logic output_enable_n,
    output logic reset_pin_n,
    input wire logic ready_level_signal
);
    import lock_ctl_pkg::*;

    typedef enum logic [3:0] {
        S_IDLE = 4'h0,
        S_CLR = 4'h1,
        S_SETUP = 4'h2,
        S_CONFIRM = 4'h3,
        S_WAIT = 4'h4,
        S_POLL = 4'h5,
        S_INFO_CMD = 4'h6,
        S_INFO_READ = 4'h7,
        S_STAT_CMD = 4'h8,
        S_STAT_READ = 4'h9
    } state_t;

    // =========================================================
    // Pin input synchronisers.
    logic [15:0] dq_meta_reg, dq_sync_reg;
    logic rdy_meta_reg, rdy_sync_reg;
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            dq_meta_reg <= 16'h0000;
            dq_sync_reg <= 16'h0000;
            rdy_meta_reg <= 1'b0;
            rdy_sync_reg <= 1'b0;
        end else begin
            dq_meta_reg <= flash_dq_in;
            dq_sync_reg <= dq_meta_reg;
            rdy_meta_reg <= ready_level_signal;
            rdy_sync_reg <= rdy_meta_reg;
        end
    end

    // =========================================================
    // Sequencer state.
    state_t state_reg, state_next;
    logic [2:0] op_reg;
    logic [22:0] target_reg;
    logic [7:0] status_reg;
    logic locked_reg, lock_fail_reg, unlock_fail_reg;
    logic [4:0] cnt_reg;
    logic phase_reg;
    logic wr_cmd_reg, rd_reg;
    logic [7:0] cmd_reg;
    logic [22:0] cmd_addr_reg;

    // A bus cycle is a strobe phase then a recovery phase; recovery
    // raises output enable so the next status read is a fresh latch.
    wire cycle_done = phase_reg && (cnt_reg == RECOVER_CYC); // [R13]
    wire strobe_end = !phase_reg && (cnt_reg == STROBE_CYC);
    wire busy = (state_reg != S_IDLE);
    wire start = reg_write && (reg_addr == REG_CTRL) && !busy;
    wire [2:0] start_op = reg_wdata[2:0];
    wire [7:0] dev_status = dq_sync_reg[7:0];
    // Busy or suspended device refuses lock traffic. The latched status is
    // judged, since the data pins carry junk once the read strobe is gone.
    wire dev_idle = status_reg[SR_READY]
        && !status_reg[SR_ERASE_PAUSED]
        && !status_reg[SR_WRITE_PAUSED]; // [R5] [R15]
    wire lock_op = (op_reg == OP_LOCK) || (op_reg == OP_UNLOCK_ALL);

    // Choose the command and address for each writing state.
    always_comb begin
        cmd_reg = CMD_ARRAY_READ;
        cmd_addr_reg = target_reg;
        unique case (state_reg)
            S_CLR: cmd_reg = CMD_STATUS_CLEAR; // [R21] [R14] [R19] [R22]
            S_SETUP: cmd_reg = CMD_LOCK_SETUP; // [R1] [R2]
            S_CONFIRM: cmd_reg = (op_reg == OP_LOCK) ? CMD_LOCK_SET
                : CMD_LOCK_CLEAR; // [R1] [R2]
            S_INFO_CMD: cmd_reg = CMD_INFO_READ;
            S_STAT_CMD: cmd_reg = CMD_STATUS_READ; // [R14]
            default: cmd_reg = CMD_ARRAY_READ;
        endcase
    end

    wire write_state = (state_reg == S_CLR) || (state_reg == S_SETUP)
        || (state_reg == S_CONFIRM) || (state_reg == S_INFO_CMD)
        || (state_reg == S_STAT_CMD);
    wire read_state = (state_reg == S_POLL) || (state_reg == S_INFO_READ)
        || (state_reg == S_STAT_READ);

    // Next state; each bus state lasts one whole bus cycle.
    always_comb begin
        state_next = state_reg;
        unique case (state_reg)
            S_IDLE: if (start) begin
                unique case (start_op)
                    OP_CLEAR: state_next = S_CLR;
                    OP_QUERY: state_next = S_INFO_CMD;
                    OP_STATUS: state_next = S_STAT_CMD;
                    default: state_next = S_STAT_CMD;
                endcase
            end
            S_CLR: if (cycle_done) state_next = lock_op ? S_SETUP : S_IDLE;
            S_SETUP: if (cycle_done) state_next = S_CONFIRM;
            S_CONFIRM: if (cycle_done) state_next = S_WAIT;
            S_WAIT: if (rdy_sync_reg) state_next = S_POLL; // [R4] [R23]
            // No status command here: setup already left status mode on.
            S_POLL: if (cycle_done) state_next = S_IDLE; // [R3]
            S_INFO_CMD: if (cycle_done) state_next = S_INFO_READ;
            S_INFO_READ: if (cycle_done) state_next = S_IDLE;
            S_STAT_CMD: if (cycle_done) begin
                state_next = S_STAT_READ;
            end
            S_STAT_READ: if (cycle_done) begin
                // Lock ops first verify the device is idle.
                state_next = !lock_op ? S_IDLE
                    : (dev_idle ? S_CLR : S_IDLE); // [R5]
            end
            default: state_next = S_IDLE;
        endcase
    end

    // =========================================================
    // Sequencer registers.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            state_reg <= S_IDLE;
            op_reg <= 3'h0;
            target_reg <= 23'h000000;
            cnt_reg <= 5'h00;
            phase_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            if (start) begin
                op_reg <= start_op;
                target_reg <= reg_wdata[30:8];
            end
            if (state_next != state_reg || state_reg == S_IDLE
                    || state_reg == S_WAIT) begin
                cnt_reg <= 5'h00;
                phase_reg <= 1'b0;
            end else if (strobe_end) begin
                cnt_reg <= 5'h00;
                phase_reg <= 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 5'h01;
            end
        end
    end

    // Results; device bits land only from single status reads and info reads.
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            status_reg <= SR_RESET; // [R11] [R20]
            locked_reg <= 1'b0;
            lock_fail_reg <= 1'b0;
            unlock_fail_reg <= 1'b0;
        end else if (strobe_end) begin
            if (state_reg == S_POLL || state_reg == S_STAT_READ) begin
                // Bit 0 forced zero; high byte ignored.
                status_reg <= {dev_status[7:1],
                    1'b0}; // [R10] [R18] [R9] [R17]
            end
            if (state_reg == S_POLL) begin
                lock_fail_reg <= (op_reg == OP_LOCK)
                    && dev_status[SR_WRITE_FAIL]; // [R7] [R6] [R16]
                unlock_fail_reg <= (op_reg == OP_UNLOCK_ALL)
                    && dev_status[SR_ERASE_FAIL]; // [R7] [R16]
            end
            if (state_reg == S_INFO_READ) begin
                locked_reg <= dq_sync_reg[0]; // [R8]
            end
        end
    end

    // =========================================================
    // Pin drive; one chip select per bus cycle, single reads only.
    wire strobing = !phase_reg && (write_state || read_state); // [R12]
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            wr_cmd_reg <= 1'b0;
            rd_reg <= 1'b0;
            flash_addr <= 23'h000000;
            flash_dq_out <= 16'h0000;
        end else begin
            wr_cmd_reg <= strobing && write_state;
            rd_reg <= strobing && read_state;
            flash_addr <= (state_reg == S_INFO_READ)
                ? target_reg + 23'(LOCK_INFO_OFFSET) : cmd_addr_reg; // [R8]
            flash_dq_out <= {8'h00, cmd_reg};
        end
    end
    assign chip_enable_n = !(wr_cmd_reg || rd_reg);
    assign write_enable_n = !wr_cmd_reg;
    assign output_enable_n = !rd_reg; // [R13]
    assign flash_dq_oe = wr_cmd_reg;
    assign reset_pin_n = 1'b1;

    // =========================================================
    // Local register read port, data one cycle after the strobe.
    logic [31:0] rdata_next;
    always_comb begin
        unique case (reg_addr)
            REG_CTRL: rdata_next = {28'h0000000, busy, op_reg};
            REG_ADDR: rdata_next = {9'h000, target_reg};
            REG_STAT: rdata_next = {24'h000000, status_reg};
            REG_RESULT: rdata_next = {29'h00000000, unlock_fail_reg,
                lock_fail_reg, locked_reg};
            default: rdata_next = 32'h00000000;
        endcase
    end
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) reg_rdata <= 32'h00000000;
        else reg_rdata <= reg_read ? rdata_next : 32'h00000000;
    end

    // =========================================================
    // Checks.
    sequence lock_pair_s;
        (state_reg == S_SETUP) ##1 (state_reg == S_SETUP) [*1];
    endsequence
    setup_then_confirm_a: assert property (@(posedge clock) // [R1]
        disable iff (!resetn) (state_reg == S_SETUP && cycle_done)
        |=> state_reg == S_CONFIRM) else $error("confirm must follow setup");
    lock_needs_idle_a: assert property (@(posedge clock) // [R5]
        disable iff (!resetn) (state_reg == S_STAT_READ && cycle_done
        && lock_op && !dev_idle) |=> state_reg == S_IDLE)
        else $error("lock issued to busy device");
    wait_on_ready_a: assert property (@(posedge clock) // [R4]
        disable iff (!resetn) (state_reg == S_WAIT && !rdy_sync_reg)
        |=> state_reg == S_WAIT) else $error("left wait while busy");
    status_bit0_a: assert property (@(posedge clock) // [R18]
        disable iff (!resetn) status_reg[0] == 1'b0)
        else $error("reserved status bit set");
    no_we_oe_a: assert property (@(posedge clock) // [R13]
        disable iff (!resetn) !(rd_reg && wr_cmd_reg))
        else $error("read and write strobes overlap");
    oe_gap_a: assert property (@(posedge clock) // [R12]
        disable iff (!resetn) $fell(rd_reg) |-> !rd_reg [*1] ##1 !rd_reg)
        else $error("output enable gap too short");
    clear_first_a: assert property (@(posedge clock) // [R21]
        disable iff (!resetn) (state_reg == S_CLR && cycle_done && lock_op)
        |=> state_reg == S_SETUP) else $error("setup must follow clear");
    info_offset_a: assert property (@(posedge clock) // [R8]
        disable iff (!resetn) (state_reg == S_INFO_READ && rd_reg)
        |-> flash_addr == target_reg + 23'(LOCK_INFO_OFFSET))
        else $error("lock query at wrong offset");
endmodule

`default_nettype wire

/* test/flash_dev_model.sv */
// Purpose: Behavioural flash device with block locks and a status byte.
// Assumes: Commands are taken after the falling write strobe while selected and act on the rising one.
// Notes: Supply level and erase suspension are set by the bench.
`timescale 1ns/1ps
`default_nettype none
module flash_dev_model #(
    parameter int BUSY_NS = 500
) (
    input wire logic [22:0] flash_addr,
    input wire logic [15:0] flash_dq_out,
    input wire logic flash_dq_oe,
    output logic [15:0] flash_dq_in,
    input wire logic chip_enable_n,
    input wire logic write_enable_n,
    input wire logic output_enable_n,
    input wire logic reset_pin_n,
    output logic ready_level_signal,
    input wire logic supply_ok,
    input wire logic erase_paused
);
    import lock_ctl_pkg::*;
    // =========================================================
    // State. Lock bits have no reset, as they are nonvolatile.
    logic [127:0] locks = '0;
    logic [5:1] err = '0;
    logic ready = 1'b1;
    logic setup_pend = 1'b0;
    logic [1:0] mode = 2'h0;
    logic [15:0] dout = 16'h0;
    logic [7:0] cmd;
    logic [7:0] status;
    event op_start;
    // Ready follows the sequencer and bit 6 the bench input; bits 2 and 0 are always zero.
    assign status = {ready, erase_paused, err[5:3], 1'h0, err[1], 1'h0};
    assign ready_level_signal = ready;
    // A released bus shows the inverse of the last value, never a hold.
    assign flash_dq_in = (!chip_enable_n && !output_enable_n) ? dout : ~dout;
    // =========================================================
    // Select, data and address are taken just after the falling write
    // strobe, since select and data enable drop with the rising one.
    logic wr_ok = 1'b0;
    logic [22:0] wr_addr = 23'h0;
    always @(negedge write_enable_n) begin
        #1;
        wr_ok = !chip_enable_n && flash_dq_oe && reset_pin_n;
        cmd = flash_dq_out[7:0];
        wr_addr = flash_addr;
    end
    // Command decoding on the rising write strobe.
    always @(posedge write_enable_n) begin
        if (wr_ok) begin
            wr_ok = 1'b0;
            if (setup_pend) begin
                setup_pend = 1'b0;
                if (erase_paused || !ready) begin
                    err[5:4] = 2'h3;
                end else if (cmd == CMD_LOCK_SET && !supply_ok) begin
                    err = err | 5'b01100;
                end else if (cmd == CMD_LOCK_CLEAR && !supply_ok) begin
                    err = err | 5'b10100;
                end else if (cmd == CMD_LOCK_SET) begin
                    locks[wr_addr[22:16]] = 1'b1;
                end else if (cmd == CMD_LOCK_CLEAR) begin
                    locks = '0;
                end else begin
                    err[5:4] = 2'h3;
                end
                -> op_start;
            end else begin
                case (cmd)
                    CMD_LOCK_SETUP: begin
                        setup_pend = 1'b1;
                        mode = 2'h1;
                    end
                    CMD_STATUS_READ: mode = 2'h1;
                    CMD_STATUS_CLEAR: err = '0;
                    CMD_INFO_READ: mode = 2'h2;
                    CMD_ARRAY_READ: mode = 2'h0;
                    default: ;
                endcase
            end
        end
    end
    // The sequencer is busy for a fixed time after each confirm.
    always @(op_start) begin
        ready = 1'b0;
        #(BUSY_NS);
        ready = 1'b1;
    end
    // Device reset clears the status but keeps the lock bits.
    always @(negedge reset_pin_n) begin
        err = '0;
        setup_pend = 1'b0;
        mode = 2'h0;
    end
    // Read data is latched once per output enable or select edge.
    always @(negedge output_enable_n or negedge chip_enable_n) begin
        // Let the address registered on the same edge settle first.
        #1;
        if (!chip_enable_n && !output_enable_n) begin
            if (mode == 2'h1) begin
                dout = {8'h00, status};
            end else if (mode == 2'h2) begin
                dout = {15'h0, locks[flash_addr[22:16]] &&
                        flash_addr[15:0] == LOCK_INFO_OFFSET};
            end else begin
                dout = 16'hffff;
            end
        end
    end
endmodule
`default_nettype wire

/* test/flash_block_lock_and_status_bench.sv */
// Purpose: Self-checking bench for the block lock host controller.
// Assumes: Local port with one-cycle strobes and next-cycle read data.
// Notes: Table rows first, then suspension, busy writes and reset.
`timescale 1ns/1ps
`default_nettype none
module flash_block_lock_and_status_bench;
    import lock_ctl_pkg::*;
    // =========================================================
    // Signals and instances.
    logic clock, resetn, reg_write, reg_read, supply_ok, erase_paused;
    logic [3:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata, d;
    logic [22:0] flash_addr;
    logic [15:0] dq_out, dq_in;
    logic dq_oe, ce_n, we_n, oe_n, rst_pin_n, ready_pin;
    int num_errors = 0;
    int n_compared = 0;
    lock_ctl dut_u (.clock(clock), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .flash_addr(flash_addr),
        .flash_dq_out(dq_out), .flash_dq_oe(dq_oe), .flash_dq_in(dq_in),
        .chip_enable_n(ce_n), .write_enable_n(we_n),
        .output_enable_n(oe_n), .reset_pin_n(rst_pin_n),
        .ready_level_signal(ready_pin));
    flash_dev_model dev_u (.flash_addr(flash_addr), .flash_dq_out(dq_out),
        .flash_dq_oe(dq_oe), .flash_dq_in(dq_in), .chip_enable_n(ce_n),
        .write_enable_n(we_n), .output_enable_n(oe_n),
        .reset_pin_n(rst_pin_n), .ready_level_signal(ready_pin),
        .supply_ok(supply_ok), .erase_paused(erase_paused));
    // =========================================================
    // Table of ordinary cases: chk bit 0 checks status, bit 1 result.
    // Result flags stand until a later operation rewrites them.
    typedef struct packed {
        logic [2:0] op;
        logic [6:0] blk;
        logic write_enable_supply;
        logic [1:0] chk;
        logic [7:0] stat;
        logic [2:0] res;
    } case_t;
    case_t rows [13] = '{
        '{OP_LOCK, 7'h3, 1'h1, 2'h3, 8'h80, 3'h0},
        '{OP_QUERY, 7'h3, 1'h1, 2'h2, 8'h00, 3'h1},
        '{OP_QUERY, 7'h4, 1'h1, 2'h2, 8'h00, 3'h0},
        '{OP_LOCK, 7'h5, 1'h0, 2'h3, 8'h98, 3'h2},
        '{OP_QUERY, 7'h5, 1'h0, 2'h2, 8'h00, 3'h2},
        '{OP_STATUS, 7'h0, 1'h0, 2'h1, 8'h98, 3'h0},
        '{OP_CLEAR, 7'h0, 1'h0, 2'h0, 8'h00, 3'h0},
        '{OP_STATUS, 7'h0, 1'h0, 2'h1, 8'h80, 3'h0},
        '{OP_UNLOCK_ALL, 7'h0, 1'h0, 2'h3, 8'ha8, 3'h4},
        '{OP_QUERY, 7'h3, 1'h1, 2'h2, 8'h00, 3'h5},
        '{OP_CLEAR, 7'h0, 1'h1, 2'h0, 8'h00, 3'h0},
        '{OP_UNLOCK_ALL, 7'h0, 1'h1, 2'h3, 8'h80, 3'h1},
        '{OP_QUERY, 7'h3, 1'h1, 2'h2, 8'h00, 3'h0}
    };
    // =========================================================
    // Clock and bus tasks.
    initial clock = 1'b0;
    always #2.5 clock = ~clock;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1 v = reg_rdata;
    endtask
    // Polling is bounded so that a stuck busy flag ends as a mismatch.
    task automatic wait_idle();
        int i;
        d = 32'h8;
        for (i = 0; i < 4000 && d[3] !== 1'b0; i++) rd(REG_CTRL, d);
        chk(32'(d[3]), 32'h0);
    endtask
    task automatic run_op(input logic [2:0] op, input logic [6:0] blk);
        wr(REG_CTRL, {1'b0, blk, 16'h0, 5'h0, op});
        wait_idle();
    endtask
    task automatic chk_reg(input logic [3:0] a, input logic [31:0] m,
                           input logic [31:0] e);
        rd(a, d);
        chk(d & m, e);
    endtask
    task automatic finish_test();
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Watchdog set far beyond the few thousand cycles the run needs.
    initial begin
        #400000;
        num_errors++;
        finish_test();
    end
    // =========================================================
    // Main sequence.
    initial begin
        resetn = 1'b0;
        {reg_write, reg_read, erase_paused, supply_ok} = 4'h1;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        repeat (10) @(posedge clock);
        resetn <= 1'b1;
        chk_reg(REG_STAT, 32'hff, 32'h80);
        foreach (rows[k]) begin
            supply_ok <= rows[k].write_enable_supply;
            run_op(rows[k].op, rows[k].blk);
            if (rows[k].chk[0])
                chk_reg(REG_STAT, 32'hff, {24'h0, rows[k].stat});
            if (rows[k].chk[1])
                chk_reg(REG_RESULT, 32'h7, {29'h0, rows[k].res});
        end
        // A suspended device must be left alone by lock requests.
        erase_paused <= 1'b1;
        run_op(OP_LOCK, 7'h6);
        chk_reg(REG_STAT, 32'hff, 32'hc0);
        erase_paused <= 1'b0;
        run_op(OP_QUERY, 7'h6);
        chk_reg(REG_RESULT, 32'h1, 32'h0);
        // A second request while busy is dropped, not queued.
        wr(REG_CTRL, {1'b0, 7'h7, 16'h0, 5'h0, OP_LOCK});
        wr(REG_CTRL, {1'b0, 7'h0, 16'h0, 5'h0, OP_UNLOCK_ALL});
        wait_idle();
        // Locks survive a reset of the controller mid-run.
        @(posedge clock);
        resetn <= 1'b0;
        repeat (3) @(posedge clock);
        chk(32'({ce_n, dq_oe}), 32'h2);
        resetn <= 1'b1;
        chk_reg(REG_STAT, 32'hff, 32'h80);
        run_op(OP_QUERY, 7'h7);
        chk_reg(REG_RESULT, 32'h1, 32'h1);
        chk_reg(4'h7, 32'hffffffff, 32'h0);
        finish_test();
    end
endmodule
`default_nettype wire
